// ===== bench/adc_board_signal_router_tb.sv
`timescale 1ns/1ps
module adc_board_signal_router_tb;
  import adc_router_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic onboard_osc_clock_in = 1'b0, external_master_clock_in = 1'b0, conversion_data_ready = 1'b0;
  logic frame_sync_mode_strap = 1'b0, onboard_osc_enable, receive_clock_pin_in, frame_sync_receive_pin_in;
  logic receive_clock_pin_out, receive_clock_pin_oe_n, transmit_clock_pin_out, transmit_clock_pin_oe_n;
  logic frame_sync_receive_pin_out, frame_sync_receive_pin_oe_n, frame_sync_copy_out, frame_sync_copy_out_oe_n;
  logic frame_sync_direction_flag, adc_master_clock, adc_serial_clock, adc_frame_sync, adc_low_io_select;
  logic host_clk, host_fs, live = 1'b0, exp_m = 1'b0, exp_s = 1'b0, mode_m = 1'b0;
  logic [1:0] exp_p = 2'h0;
  logic [2:0] exp_f = 3'h0;
  logic [3:0] ctrl_m = 4'h0;
  integer seed = 32'h3b9a486f, n_fail = 0, n_tests = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  // Two-way pins: device wins while its enable is low
  assign receive_clock_pin_in = receive_clock_pin_oe_n ? host_clk : receive_clock_pin_out;
  assign frame_sync_receive_pin_in = frame_sync_receive_pin_oe_n ? host_fs : frame_sync_receive_pin_out;
  adc_board_signal_router dut_u (.*);
  adc_router_host_model host_u (.pclk(pclk), .frame_sync_direction_flag(frame_sync_direction_flag),
    .host_clk(host_clk), .host_fs(host_fs));
  task chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One bus transfer; the response flag rides above the data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({pslverr, w ? 32'h0 : prdata}, e, "bus");
    {psel, penable} <= 2'b00;
    if (w && a == CTRL_OFFSET) ctrl_m = d[3:0];
  endtask
  // Random sources, plus the hang limit
  always @(posedge pclk) begin
    {onboard_osc_clock_in, external_master_clock_in, conversion_data_ready} <= 3'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // Reference model of the clock and frame sync muxes, one edge of delay
  always @(posedge pclk) begin
    #1;
    if (live) begin
      chk(33'(adc_master_clock), 33'(exp_m), "master clock");
      chk(33'(adc_serial_clock), 33'(exp_s), "serial clock");
      chk(33'({receive_clock_pin_out, transmit_clock_pin_out}), 33'(exp_p), "clock pins");
      chk(33'({frame_sync_receive_pin_out, frame_sync_copy_out, adc_frame_sync}), 33'(exp_f), "frame");
    end
    exp_m = ctrl_m[2] ? onboard_osc_clock_in : external_master_clock_in;
    exp_s = ctrl_m[0] ? exp_m : receive_clock_pin_in;
    exp_p = {ctrl_m[0] & exp_m, ctrl_m[1] & exp_m};
    exp_f = mode_m ? {1'b0, {2{frame_sync_receive_pin_in}}} : {conversion_data_ready, 2'b00};
  end
  initial begin
    for (int m = 0; m < 2; m++) begin
      live = 1'b0;
      presetn <= 1'b0;
      frame_sync_mode_strap <= m[0];
      mode_m = m[0];
      ctrl_m = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      live = 1'b1;
      apb(1'b0, STATUS_OFFSET, 32'h0, 33'({m[0], m[0]}));
      apb(1'b0, OSC_FREQ_OFFSET, 32'h0, 33'h17d7840);
      apb(1'b1, OSC_FREQ_OFFSET, 32'h1, 33'h0);
      apb(1'b0, 8'h0c, 32'h0, 33'h100000000);
      for (int i = 0; i < 16; i++) begin
        apb(1'b1, CTRL_OFFSET, 32'(i), 33'h0);
        repeat (2) @(posedge pclk);
        chk(33'({adc_low_io_select, onboard_osc_enable, transmit_clock_pin_oe_n, receive_clock_pin_oe_n}),
          33'({i[3], i[2], !i[1], !i[0]}), "pins");
        chk(33'(transmit_clock_pin_out), 33'(i[1] & adc_master_clock), "xmit");
        apb(1'b0, STATUS_OFFSET, 32'h0, 33'({i[1], i[0], i[2], m[0], m[0]}));
        apb(1'b0, CTRL_OFFSET, 32'h0, 33'(i));
      end
      chk(33'({frame_sync_receive_pin_oe_n, frame_sync_copy_out_oe_n}), 33'({m[0], !m[0]}), "fs");
      frame_sync_mode_strap <= !m[0];
      repeat (4) @(posedge pclk);
      chk(33'(frame_sync_direction_flag), 33'(m[0]), "flag");
    end
    results();
  end
endmodule
bind adc_board_signal_router adc_router_assertions chk_u (.*);

// ===== bench/adc_router_assertions.sv
`timescale 1ns/1ps
module adc_router_assertions (
  // Bus, clocks and pins, all one bit
  input wire logic pclk, presetn, psel, penable, pready, pslverr, onboard_osc_clock_in, external_master_clock_in,
  input wire logic onboard_osc_enable, adc_master_clock, receive_clock_pin_in, receive_clock_pin_out,
  input wire logic receive_clock_pin_oe_n, adc_serial_clock, transmit_clock_pin_out, transmit_clock_pin_oe_n,
  input wire logic conversion_data_ready, frame_sync_receive_pin_in, frame_sync_receive_pin_out,
  input wire logic frame_sync_receive_pin_oe_n, frame_sync_copy_out, frame_sync_copy_out_oe_n,
  input wire logic frame_sync_direction_flag, adc_frame_sync
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs settle two edges after reset
  logic [1:0] up;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 2'b00;
    else up <= {up[0], 1'b1};
  end
  bus_answer_a: assert property (psel && !penable |-> !pready ##2 pready ##1 !pready)
    else $error("bus answer timing wrong");
  route_out_a: assert property (!receive_clock_pin_oe_n |-> adc_serial_clock == receive_clock_pin_out)
    else $error("serial clock not driven out");
  route_in_a: assert property (up[1] && receive_clock_pin_oe_n |-> adc_serial_clock == $past(receive_clock_pin_in))
    else $error("serial clock not from pin");
  xmit_on_a: assert property (!transmit_clock_pin_oe_n |-> transmit_clock_pin_out == adc_master_clock)
    else $error("transmit pin not master");
  xmit_off_a: assert property (transmit_clock_pin_oe_n |-> !transmit_clock_pin_out)
    else $error("transmit pin active");
  master_src_a: assert property (up[1] |-> adc_master_clock == (onboard_osc_enable ?
    $past(onboard_osc_clock_in) : $past(external_master_clock_in))) else $error("master source wrong");
  reg_mode_a: assert property (up[1] && !frame_sync_direction_flag |-> !frame_sync_receive_pin_oe_n &&
    frame_sync_copy_out_oe_n && frame_sync_receive_pin_out == $past(conversion_data_ready)) else $error("ready path");
  frame_mode_a: assert property (up[1] && frame_sync_direction_flag |-> frame_sync_receive_pin_oe_n &&
    !frame_sync_copy_out_oe_n && frame_sync_copy_out == $past(frame_sync_receive_pin_in) && adc_frame_sync ==
    frame_sync_copy_out) else $error("frame sync path");
  mode_static_a: assert property (up[1] && $past(up[1]) |-> $stable(frame_sync_direction_flag))
    else $error("mode changed");
  cover property (!receive_clock_pin_oe_n);
  cover property (!frame_sync_copy_out_oe_n);
  cover property (pready && pslverr);
endmodule

// ===== bench/adc_router_host_model.sv
`timescale 1ns/1ps
module adc_router_host_model (
  input wire logic pclk,
  input wire logic frame_sync_direction_flag,
  output logic host_clk = 1'b0,
  output logic host_fs = 1'b0
);
  logic [2:0] cnt = 3'h0;
  // Slow clock keeps sampling at the bus rate free of aliasing
  always @(posedge pclk) begin
    cnt <= cnt + 3'h1;
    host_clk <= cnt[1];
    host_fs <= frame_sync_direction_flag ? (cnt == 3'h7) : ~host_fs;
  end
endmodule

// ===== logic/adc_board_signal_router.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// - Route low: pin is input to serial clock
// - Route high: serial clock is master, driven out
// - Route select defaults low after reset
// - Transmit enable high: master clock drives transmit pin
// - Transmit enable low: transmit pin undriven, default low
// - Oscillator select high: enable oscillator, use it
// - Onboard oscillator fixed at 25 MHz
// - Select low: external clock, oscillator off, default
// - Interface mode is a static strap only
// - Register mode: first data-ready to frame pin
// - Frame mode: pin drives both converters, copied out
// - Direction flag high in frame mode, else low
// - Header and converter sides use separate levels
// - Serial clock: host clock low, master clock high
module adc_board_signal_router
  import adc_router_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources
  input wire logic onboard_osc_clock_in,
  input wire logic external_master_clock_in,
  output logic onboard_osc_enable,
  // Header side pins
  input wire logic receive_clock_pin_in,
  output logic receive_clock_pin_out,
  output logic receive_clock_pin_oe_n,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_n,
  input wire logic frame_sync_receive_pin_in,
  output logic frame_sync_receive_pin_out,
  output logic frame_sync_receive_pin_oe_n,
  output logic frame_sync_copy_out,
  output logic frame_sync_copy_out_oe_n,
  output logic frame_sync_direction_flag,
  // Mode strap, read once after reset
  input wire logic frame_sync_mode_strap,
  // Converter side pins
  input wire logic conversion_data_ready,
  output logic adc_master_clock,
  output logic adc_serial_clock,
  output logic adc_frame_sync,
  output logic adc_low_io_select
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ctrl_s ctrl_reg;
  logic mode_reg;
  logic mode_taken_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic rd_err_next;
  logic access;
  logic master_src;
  // Decoded strobes and mode
  logic ctrl_write;
  logic answer_due;
  logic frame_mode;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state so read data and pready both leave flip-flops
  assign access = psel && penable;

  // ----------------------------------------
  // Decoded strobes
  // ----------------------------------------
  // First access cycle arms the answer for the next edge
  assign answer_due = access && !pready_reg;

  // Completing cycle only, so a write lands exactly once
  assign ctrl_write = access && pready_reg && pwrite && (paddr == CTRL_OFFSET);

  // Read mux and unmapped detection
  // Writes to read-only words are dropped without an error
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_err_next = 1'b0;
    unique case (paddr)
      CTRL_OFFSET: begin
        rd_next[CTRL_WIDTH-1:0] = ctrl_reg;
      end
      STATUS_OFFSET: begin
        rd_next[STAT_MODE_BIT] = mode_reg;
        rd_next[STAT_DIR_BIT] = frame_sync_direction_flag;
        rd_next[STAT_OSC_BIT] = onboard_osc_enable;
        rd_next[STAT_ROUTE_BIT] = ctrl_reg.recv_clock_route_select;
        rd_next[STAT_XMIT_BIT] = ctrl_reg.xmit_clock_out_enable;
      end
      OSC_FREQ_OFFSET: begin
        rd_next = ONBOARD_OSC_FREQ_HZ;
      end
      default: begin
        rd_err_next = 1'b1;
      end
    endcase
  end

  // Answer handshake: pready high for exactly one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= answer_due;
    end
  end

  // Error flag rides with pready; unmapped offsets only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= answer_due && rd_err_next;
    end
  end

  // Read data zero outside its cycle, so stale words never leak
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (answer_due && !pwrite) begin
      prdata_reg <= rd_next;
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Control register; only the write that completes takes effect
  // Upper write bits are dropped and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= ctrl_s'(pwdata[CTRL_WIDTH-1:0]);
    end
  end

  // ----------------------------------------
  // Interface mode strap
  // ----------------------------------------
  // Caught once after release; no bus write reaches it
  // A strap moved in service cannot turn pins under a live host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= REGISTER_MODE;
      mode_taken_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      mode_reg <= frame_sync_mode_strap;
      mode_taken_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Master clock selection
  // ----------------------------------------
  // Clocks are sampled at pclk, so only slow test clocks pass cleanly
  assign master_src = ctrl_reg.onboard_osc_select ? onboard_osc_clock_in
                                                  : external_master_clock_in;

  // Oscillator enable; off in the external setting to save power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onboard_osc_enable <= 1'b0;
    end else begin
      onboard_osc_enable <= ctrl_reg.onboard_osc_select;
    end
  end

  // Converter master clock from the chosen source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_master_clock <= 1'b0;
    end else begin
      adc_master_clock <= master_src;
    end
  end

  // ----------------------------------------
  // Serial clock routing
  // ----------------------------------------
  // When routed, taken from the same source as the master clock to stay in step; else from the receive pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_serial_clock <= 1'b0;
    end else if (ctrl_reg.recv_clock_route_select) begin
      adc_serial_clock <= master_src;
    end else begin
      adc_serial_clock <= receive_clock_pin_in;
    end
  end

  // Receive pin driven only when routed, else left to the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_clock_pin_out <= 1'b0;
      receive_clock_pin_oe_n <= 1'b1;
    end else if (ctrl_reg.recv_clock_route_select) begin
      receive_clock_pin_out <= master_src;
      receive_clock_pin_oe_n <= 1'b0;
    end else begin
      receive_clock_pin_out <= 1'b0;
      receive_clock_pin_oe_n <= 1'b1;
    end
  end

  // Transmit clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe_n <= 1'b1;
    end else begin
      transmit_clock_pin_out <= ctrl_reg.xmit_clock_out_enable ? master_src : 1'b0;
      transmit_clock_pin_oe_n <= !ctrl_reg.xmit_clock_out_enable;
    end
  end

  // ----------------------------------------
  // Frame sync and data ready steering
  // ----------------------------------------
  // The second converter's data-ready has no port: it goes nowhere
  assign frame_mode = (mode_reg == FRAME_SYNC_MODE);

  // Header frame pin carries data-ready out in register mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_receive_pin_out <= 1'b0;
      frame_sync_receive_pin_oe_n <= 1'b1;
    end else if (frame_mode) begin
      frame_sync_receive_pin_out <= 1'b0;
      frame_sync_receive_pin_oe_n <= 1'b1;
    end else begin
      frame_sync_receive_pin_out <= conversion_data_ready;
      frame_sync_receive_pin_oe_n <= 1'b0;
    end
  end

  // Copy output for stacked boards; released in register mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_copy_out <= 1'b0;
      frame_sync_copy_out_oe_n <= 1'b1;
    end else if (frame_mode) begin
      frame_sync_copy_out <= frame_sync_receive_pin_in;
      frame_sync_copy_out_oe_n <= 1'b0;
    end else begin
      frame_sync_copy_out <= 1'b0;
      frame_sync_copy_out_oe_n <= 1'b1;
    end
  end

  // One frame sync feeds both converters; held low when unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_frame_sync <= 1'b0;
    end else if (frame_mode) begin
      adc_frame_sync <= frame_sync_receive_pin_in;
    end else begin
      adc_frame_sync <= 1'b0;
    end
  end

  // Direction flag tells the host which way the frame pin points
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_direction_flag <= 1'b0;
    end else begin
      frame_sync_direction_flag <= frame_mode;
    end
  end

  // ----------------------------------------
  // Level translation
  // ----------------------------------------
  // Converter-side supply choice, independent of the header level
  // The header keeps its own level; nothing here depends on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_low_io_select <= 1'b0;
    end else begin
      adc_low_io_select <= ctrl_reg.adc_low_io;
    end
  end

endmodule

// ===== logic/adc_router_pkg.sv
package adc_router_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] OSC_FREQ_OFFSET = 8'h08;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int CTRL_WIDTH = 4;
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_DIR_BIT = 1;
  localparam int STAT_OSC_BIT = 2;
  localparam int STAT_ROUTE_BIT = 3;
  localparam int STAT_XMIT_BIT = 4;

  // Control word, LSB first: route, transmit enable, osc select, low io
  typedef struct packed {
    logic adc_low_io;
    logic onboard_osc_select;
    logic xmit_clock_out_enable;
    logic recv_clock_route_select;
  } ctrl_s;

  // All low, the state that pulldowns would give
  localparam ctrl_s CTRL_RESET = '{default: 1'b0};

  // ----------------------------------------
  // Fixed figures
  // ----------------------------------------
  localparam logic [31:0] ONBOARD_OSC_FREQ_HZ = 32'd25_000_000;
  localparam logic FRAME_SYNC_MODE = 1'b1;
  localparam logic REGISTER_MODE = 1'b0;

endpackage
